// [design/axis_channel_matrix_mixer.sv]
// matrix mixing datapath: input matrix, force selector, velocity, output matrix, queries
// assumes channel samples and axis control values arrive synchronous with a sample strobe
`timescale 1ns/100ps
`default_nettype none
module axis_channel_matrix_mixer (
   input  wire logic                                    CLK_IN,
   input  wire logic                                    RESET_IN,
   input  wire logic                                    ANALOG_VARIANT_IN,
   input  wire logic                                    SAMPLE_IN,
   input  wire logic [mixer_pkg::N_IN*mixer_pkg::DW-1:0]   CHANNEL_IN,
   input  wire logic [mixer_pkg::N_AXIS*mixer_pkg::DW-1:0] CONTROL_IN,
   input  wire logic [mixer_pkg::N_AXIS*2-1:0]             CONTROL_MODE_SELECT_IN,
   input  wire logic [1:0]                                 MONITOR_SELECT_IN,
   input  wire mixer_pkg::param_write_t                    PARAM_IN,
   input  wire logic [mixer_pkg::N_IN*mixer_pkg::NAME_W-1:0] CHANNEL_NAME_IN,
   input  wire mixer_pkg::query_t                          QUERY_IN,
   output logic [mixer_pkg::N_AXIS*mixer_pkg::DW-1:0]      POSITION_OUT,
   output logic [mixer_pkg::N_AXIS*mixer_pkg::DW-1:0]      VELOCITY_OUT,
   output logic [mixer_pkg::N_AXIS*mixer_pkg::DW-1:0]      ACTUAL_CONTROL_VALUE_OUT,
   output logic [mixer_pkg::N_OUT*mixer_pkg::DW-1:0]       DRIVE_OUT,
   output logic [mixer_pkg::N_AXIS*mixer_pkg::NAME_W-1:0]  MECHANICS_NAME_OUT,
   output logic [mixer_pkg::DW-1:0]                        QUERY_VALUE_OUT,
   output logic                                           RESULT_VALID_OUT
);
   import mixer_pkg::*;

   logic [CW-1:0] in_coef_q  [N_AXIS][N_IN];
   logic [CW-1:0] out_coef_q [N_OUT][N_AXIS];
   logic [2:0]    force_ch_q [N_AXIS];
   logic [CW-1:0] in_act     [N_AXIS][N_IN];
   logic [CW-1:0] out_act    [N_OUT][N_AXIS];
   logic signed [DW-1:0] pos_d [N_AXIS];
   logic signed [DW-1:0] force_val [N_AXIS];
   logic signed [DW-1:0] drv_d [N_OUT];
   logic signed [DW-1:0] pos_prev_q [N_AXIS];
   logic [N_AXIS*DW-1:0] pos_q, vel_q, cav_q;
   logic [N_OUT*DW-1:0]  drv_q;
   logic [N_AXIS*NAME_W-1:0] name_q;
   logic [DW-1:0] query_q;
   logic [DW-1:0] query_d;
   logic          valid_q;
   logic          analog_var_q;

   // coefficient writes; a write in the sample cycle is seen by the next sample
   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         for (int a = 0; a < N_AXIS; a++) begin
            force_ch_q[a] <= FORCE_NONE;
            for (int c = 0; c < N_IN; c++)
               in_coef_q[a][c] <= (c == a) ? COEF_ONE : COEF_ZERO;
         end
         for (int o = 0; o < N_OUT; o++)
            for (int a = 0; a < N_AXIS; a++)
               out_coef_q[o][a] <= (o == a) ? COEF_ONE : COEF_ZERO;
      end else if (PARAM_IN.valid) begin
         for (int c = 0; c < N_IN; c++)
            if (PARAM_IN.ident == ID_IN_COEF + 32'(c))
               in_coef_q[PARAM_IN.axis][c] <= PARAM_IN.value;
         for (int o = 0; o < N_OUT; o++)
            if (PARAM_IN.ident == ID_OUT_COEF + 32'(o))
               out_coef_q[o][PARAM_IN.axis] <= PARAM_IN.value;
         if (PARAM_IN.ident == ID_FORCE_CH)
            force_ch_q[PARAM_IN.axis] <= PARAM_IN.value[2:0];
      end
   end

   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN)
         analog_var_q <= 1'b0;
      else
         analog_var_q <= ANALOG_VARIANT_IN;
   end

   genvar ga, gc, go;
   generate
      for (ga = 0; ga < N_AXIS; ga++) begin : g_axis
         for (gc = 0; gc < N_IN; gc++) begin : g_in
            assign in_act[ga][gc] = (gc >= N_IN_BASE && !analog_var_q) ? COEF_ZERO : in_coef_q[ga][gc];
         end
         always_comb begin
            logic signed [DW+CW+3:0] acc;
            acc = '0;
            for (int c = 0; c < N_IN; c++)
               acc = acc + (DW+CW+4)'($signed(CHANNEL_IN[c*DW +: DW]) * $signed(in_act[ga][c]));
            pos_d[ga] = DW'(acc >>> CFRAC);
         end
         assign force_val[ga] = (force_ch_q[ga] == FORCE_NONE || force_ch_q[ga] > 3'(N_IN)
                                 || (force_ch_q[ga] > 3'(N_IN_BASE) && !analog_var_q)) ? '0
                                : $signed(CHANNEL_IN[(32'(force_ch_q[ga]) - 1)*DW +: DW]);
      end
      for (go = 0; go < N_OUT; go++) begin : g_out
         for (ga = 0; ga < N_AXIS; ga++) begin : g_oc
            assign out_act[go][ga] = (go >= N_OUT_BASE && !analog_var_q) ? COEF_ZERO : out_coef_q[go][ga];
         end
         always_comb begin
            logic signed [DW+CW+1:0] acc;
            logic signed [DW-1:0] mon;
            mon = $signed(pos_q[(go % N_AXIS)*DW +: DW]);
            acc = '0;
            for (int a = 0; a < N_AXIS; a++)
               acc = acc + (DW+CW+2)'($signed(CONTROL_IN[a*DW +: DW]) * $signed(out_act[go][a]));
            if (go >= N_OUT_BASE && MONITOR_SELECT_IN[go % N_OUT_BASE] && analog_var_q)
               drv_d[go] = mon;
            else
               drv_d[go] = DW'(acc >>> CFRAC);
         end
      end
   endgenerate

   // datapath registers update once per sample strobe; the valid flag takes the strobe value every clock
   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         pos_q   <= '0;
         vel_q   <= '0;
         cav_q   <= '0;
         drv_q   <= '0;
         name_q  <= '0;
         valid_q <= 1'b0;
         for (int a = 0; a < N_AXIS; a++)
            pos_prev_q[a] <= '0;
      end else begin
         valid_q <= SAMPLE_IN;
         if (SAMPLE_IN) begin
            for (int a = 0; a < N_AXIS; a++) begin
               pos_q[a*DW +: DW] <= pos_d[a];
               pos_prev_q[a]     <= pos_d[a];
               vel_q[a*DW +: DW] <= DW'(pos_d[a] - pos_prev_q[a]);
               case (control_mode_t'(CONTROL_MODE_SELECT_IN[a*2 +: 2]))
                  MODE_VELOCITY: cav_q[a*DW +: DW] <= DW'(pos_d[a] - pos_prev_q[a]);
                  MODE_FORCE:    cav_q[a*DW +: DW] <= force_val[a];
                  default:       cav_q[a*DW +: DW] <= pos_d[a];
               endcase
               name_q[a*NAME_W +: NAME_W] <= '0;
               for (int c = N_IN - 1; c >= 0; c--)
                  if (in_act[a][c] != COEF_ZERO)
                     name_q[a*NAME_W +: NAME_W] <= CHANNEL_NAME_IN[c*NAME_W +: NAME_W];
            end
            for (int o = 0; o < N_OUT; o++)
               drv_q[o*DW +: DW] <= drv_d[o];
         end
      end
   end

   // query mux: output value, commanded control value, channel value
   always_comb begin
      query_d = '0;
      case (QUERY_IN.sel)
         QSEL_OUTPUT:  if (QUERY_IN.index < 3'(N_OUT)) query_d = drv_q[QUERY_IN.index[1:0]*DW +: DW];
         QSEL_CONTROL: if (QUERY_IN.index < 3'(N_AXIS)) query_d = CONTROL_IN[QUERY_IN.index[0]*DW +: DW];
         QSEL_CHANNEL: if (QUERY_IN.index < 3'(N_IN)) query_d = CHANNEL_IN[32'(QUERY_IN.index)*DW +: DW];
         default:      query_d = '0;
      endcase
   end

   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN)
         query_q <= '0;
      else
         query_q <= query_d;
   end

   assign POSITION_OUT             = pos_q;
   assign VELOCITY_OUT             = vel_q;
   assign ACTUAL_CONTROL_VALUE_OUT = cav_q;
   assign DRIVE_OUT                = drv_q;
   assign MECHANICS_NAME_OUT       = name_q;
   assign QUERY_VALUE_OUT          = query_q;
   assign RESULT_VALID_OUT         = valid_q;

   a_sample_valid: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      SAMPLE_IN |=> RESULT_VALID_OUT)
      else $error("valid not raised after sample");
   a_hold_between: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      !SAMPLE_IN |=> $stable(POSITION_OUT))
      else $error("position changed without sample");
   a_pos_capture: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      SAMPLE_IN |=> POSITION_OUT[DW-1:0] == $past(pos_d[0]))
      else $error("axis position not captured");
   a_vel_diff: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      SAMPLE_IN |=> VELOCITY_OUT[DW-1:0] == DW'(POSITION_OUT[DW-1:0] - $past(pos_prev_q[0])))
      else $error("velocity not position difference");
   a_force_mode: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      SAMPLE_IN && CONTROL_MODE_SELECT_IN[1:0] == 2'h2
      |=> ACTUAL_CONTROL_VALUE_OUT[DW-1:0] == $past(force_val[0]))
      else $error("force mode actual value wrong");
   a_force_axis2: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      SAMPLE_IN && CONTROL_MODE_SELECT_IN[3:2] == 2'h2
      |=> ACTUAL_CONTROL_VALUE_OUT[2*DW-1 -: DW] == $past(force_val[1]))
      else $error("axis two force value wrong");
   a_base_inputs: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      !analog_var_q |-> in_act[0][4] == COEF_ZERO && in_act[1][5] == COEF_ZERO)
      else $error("absent channel weight nonzero");
   a_base_outputs: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      SAMPLE_IN && !analog_var_q |=> DRIVE_OUT[N_OUT*DW-1 -: DW] == '0)
      else $error("absent output driven");
   a_ctl_query: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
      QUERY_IN.sel == QSEL_CONTROL && QUERY_IN.index == 3'h1
      |=> QUERY_VALUE_OUT == $past(CONTROL_IN[2*DW-1 -: DW]))
      else $error("control query wrong");
endmodule
`default_nettype wire

// [design/mixer_pkg.sv]
// constants, types and parameter identifiers for the axis channel matrix mixer
// assumes one controller clock; coefficients are loaded by a configuring host over plain ports
package mixer_pkg;
   localparam int N_IN   = 6;
   localparam int N_OUT  = 4;
   localparam int N_AXIS = 2;
   localparam int N_IN_BASE  = 4;
   localparam int N_OUT_BASE = 2;
   localparam int DW = 24;
   localparam int CW = 16;
   localparam int CFRAC = 12;
   localparam int NAME_W = 8;
   localparam logic [31:0] ID_IN_COEF  = 32'h07000500;
   localparam logic [31:0] ID_FORCE_CH = 32'h07000400;
   localparam logic [31:0] ID_OUT_COEF = 32'h09000000;
   localparam logic [31:0] ID_MECH_NAME = 32'h0f000100;
   localparam logic [CW-1:0] COEF_ONE  = 16'h1000;
   localparam logic [CW-1:0] COEF_ZERO = 16'h0000;
   localparam logic [2:0]    FORCE_NONE = 3'h0;
   localparam logic [1:0]    QSEL_OUTPUT = 2'h0;
   localparam logic [1:0]    QSEL_CONTROL = 2'h1;
   localparam logic [1:0]    QSEL_CHANNEL = 2'h2;
   typedef enum logic [1:0] {MODE_POSITION, MODE_VELOCITY, MODE_FORCE} control_mode_t;
   typedef struct packed {
      logic        valid;
      logic [31:0] ident;
      logic [0:0]  axis;
      logic [CW-1:0] value;
   } param_write_t;
   typedef struct packed {
      logic [1:0]  sel;
      logic [2:0]  index;
   } query_t;
endpackage

// [testbench/sensor_model.sv]
// sensor-side model: six channel values around a base level
// assumes the bench moves the base level between samples
`timescale 1ns/100ps
`default_nettype none
module sensor_model (
   input  wire logic [23:0]  BASE_IN,
   output logic      [143:0] CHANNEL_OUT
);
   always_comb begin
      for (int c = 0; c < 6; c++) begin
         CHANNEL_OUT[c*24 +: 24] = BASE_IN + 24'(c * 16);
      end
   end
endmodule
`default_nettype wire

// [testbench/axis_channel_matrix_mixer_tb.sv]
// self-checking bench for the matrix mixer
// assumes the design package is compiled first
`timescale 1ns/100ps
`default_nettype none
module axis_channel_matrix_mixer_tb;
   import mixer_pkg::*;
   logic         clk = 1'b0;
   logic         rst, analog, samp, rv;
   logic [23:0]  base, qv;
   logic [143:0] chan;
   logic [47:0]  ctl, pos, vel, act, names;
   logic [95:0]  drv;
   logic [3:0]   mode;
   logic [1:0]   mon;
   logic [15:0]  mech;
   param_write_t pw;
   query_t       qry;
   int           n_errors, checks;
   sensor_model sens (.BASE_IN(base), .CHANNEL_OUT(chan));
   axis_channel_matrix_mixer dut (
      .CLK_IN(clk), .RESET_IN(rst), .ANALOG_VARIANT_IN(analog), .SAMPLE_IN(samp),
      .CHANNEL_IN(chan), .CONTROL_IN(ctl), .CONTROL_MODE_SELECT_IN(mode),
      .MONITOR_SELECT_IN(mon), .PARAM_IN(pw), .CHANNEL_NAME_IN(names), .QUERY_IN(qry),
      .POSITION_OUT(pos), .VELOCITY_OUT(vel), .ACTUAL_CONTROL_VALUE_OUT(act),
      .DRIVE_OUT(drv), .MECHANICS_NAME_OUT(mech), .QUERY_VALUE_OUT(qv), .RESULT_VALID_OUT(rv));
   always #2.5 clk = ~clk;
   function automatic logic [23:0] chv(input int c);
      return base + 24'(c * 16);
   endfunction
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic put(input logic [31:0] id, input logic ax, input logic [15:0] v);
      @(posedge clk) pw <= '{1'b1, id, ax, v};
      @(posedge clk) pw.valid <= 1'b0;
   endtask
   task automatic sample;
      @(posedge clk) samp <= 1'b1;
      @(posedge clk) samp <= 1'b0;
      for (int i = 0; i < 4 && rv !== 1'b1; i++) begin
         #1;
         if (rv !== 1'b1) @(posedge clk);
      end
      if (rv !== 1'b1) begin
         n_errors++;
         close_out;
      end
   endtask
   task automatic ask(input query_t qq, input logic [23:0] e);
      @(posedge clk) qry <= qq;
      repeat (2) @(posedge clk);
      #1 check(qv, e);
   endtask
   task automatic t_identity;
      @(posedge clk) ctl <= {24'd200, 24'd100};
      sample;
      check(pos[23:0], chv(0));
      check(pos[47:24], chv(1));
      check(drv[23:0], 24'd100);
      check(drv[47:24], 24'd200);
      check(drv[71:48], 24'h0);
      check(drv[95:72], 24'h0);
      @(posedge clk) #1 check({23'h0, rv}, 24'h0);
      $display("identity test done");
   endtask
   task automatic t_matrix;
      put(ID_IN_COEF + 2, 1'b0, 16'h2000);
      put(ID_IN_COEF, 1'b0, COEF_ZERO);
      put(ID_IN_COEF + 4, 1'b0, COEF_ONE);
      put(ID_IN_COEF + 32'h100, 1'b1, COEF_ZERO);
      put(ID_OUT_COEF + 1, 1'b0, 16'h0800);
      sample;
      check(pos[23:0], 24'(2 * chv(2)));
      check(pos[47:24], chv(1));
      check(drv[47:24], 24'd250);
      check({16'h0, mech[7:0]}, 24'ha2);
      check({16'h0, mech[15:8]}, 24'ha1);
      $display("matrix test done");
   endtask
   task automatic t_force;
      @(posedge clk) mode <= 4'b1000;
      put(ID_FORCE_CH, 1'b1, 16'h0004);
      sample;
      check(act[47:24], chv(3));
      check(act[23:0], 24'(2 * chv(2)));
      $display("force test done");
   endtask
   task automatic t_velocity;
      @(posedge clk) mode <= 4'b0100;
      base <= base + 24'd5;
      sample;
      check(vel[47:24], 24'd5);
      check(vel[23:0], 24'd10);
      check(act[47:24], 24'd5);
      ask('{QSEL_CONTROL, 3'h1}, 24'd200);
      ask('{QSEL_OUTPUT, 3'h1}, 24'd250);
      ask('{QSEL_CHANNEL, 3'h0}, chv(0));
      $display("velocity and query test done");
   endtask
   task automatic t_analog;
      @(posedge clk) analog <= 1'b1;
      mon <= 2'b01;
      sample;
      check(pos[23:0], 24'(2 * chv(2) + chv(4)));
      check(drv[71:48], 24'(2 * chv(2)));
      check(drv[95:72], 24'h0);
      $display("analog test done");
   endtask
   initial begin
      rst = 1; analog = 0; samp = 0; base = 24'h100; ctl = '0; mode = '0; mon = '0;
      pw = '0; qry = '0; names = 48'ha5a4a3a2a1a0; n_errors = 0; checks = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_identity;
      t_matrix;
      t_force;
      t_velocity;
      t_analog;
      close_out;
   end
endmodule
`default_nettype wire
